// *** bench/smte_slave_model.sv ***
// Behavioural serial slave that answers the engine on select line zero.
`timescale 1ns/1ps
module smte_slave_model (
    input wire logic mclk,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic sck_q = 1'b0;
    logic sel_q = 1'b0;
    logic [7:0] sh = 8'h00;
    int bits = 0;
    // Start from known line levels.
    initial begin
        miso = 1'b0;
        got = 8'h00;
    end
    // The leading edge leaves the idle level; the phase picks the sampling edge.
    always @(posedge mclk) begin
        sck_q <= sck;
        sel_q <= !sel_n;
        if (sel_n) begin
            miso <= ~miso; // A released line never holds the last bit.
            bits <= 0;
        end else if (!sel_q) begin
            sh <= reply;
            miso <= reply[7];
        end else if (sck !== sck_q && sck_q === cpol) begin
            if (cpha) miso <= sh[7];
            else got <= {got[6:0], mosi};
        end else if (sck !== sck_q) begin
            if (cpha) got <= {got[6:0], mosi};
            bits <= (bits == 7) ? 0 : bits + 1;
            sh <= (bits == 7) ? reply : {sh[6:0], 1'b0};
            if (!cpha) miso <= (bits == 7) ? reply[7] : sh[6];
        end
    end
endmodule // smte_slave_model

// *** bench/smte_top_tb.sv ***
// Self-checking bench for the serial master transfer engine.
`timescale 1ns/1ps
module smte_top_tb;
    logic mclk = 1'b0, rst = 1'b1, spi_enable = 1'b0, cpol = 1'b0, cpha = 1'b0;
    logic [7:0] baud_div = 8'h03, itd = 8'h00, tx_data = 8'h00, reply = 8'h00;
    logic wrbs = 1'b0, tx_valid = 1'b0, rx_read = 1'b0, status_read = 1'b0;
    logic [1:0] sel = 2'h0;
    logic tx_ready, empty, done, rx_full, ovr, sck, mosi, miso;
    logic [7:0] rx_reg, s_got;
    logic [3:0] cs_n;
    logic sck_q = 1'b0, cs_q = 1'b1;
    int cyc = 0, edges = 0, last_edge = 0, cs_rises = 0, cs_rise_at = 0;
    int empty_lows = 0, mark_e = 0, mark_l = 0;
    int miscompares = 0, cmp_count = 0, acc, gap;
    logic [7:0] v;
    ////////////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period of 2 ns.
    always #2 mclk = ~mclk;
    smte_top i_dut (.mclk(mclk), .rst(rst), .spi_enable(spi_enable), .cpol(cpol),
        .cpha(cpha), .baud_div(baud_div), .inter_transfer_delay(itd),
        .wait_read_before_send(wrbs), .slave_select_field(sel), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_read(rx_read),
        .status_read(status_read), .rx_holding_reg(rx_reg), .tx_holding_empty(empty),
        .tx_all_done(done), .rx_holding_full(rx_full), .rx_overrun_flag(ovr),
        .serial_clock_out(sck), .mosi(mosi), .miso(miso), .cs_n(cs_n));
    smte_slave_model i_slave (.mclk(mclk), .cpol(cpol), .cpha(cpha), .sck(sck),
        .mosi(mosi), .sel_n(cs_n[0]), .reply(reply), .miso(miso), .got(s_got));
    ////////////////////////////////////////////////////////////////////////////////
    // Watches the wire: clock edges inside a frame, select rises and the empty flag.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        sck_q <= sck;
        cs_q <= cs_n[0];
        if (sck !== sck_q && cs_n[0] === 1'b0) begin
            edges <= edges + 1;
            last_edge <= cyc;
        end
        if (cs_n[0] === 1'b1 && cs_q === 1'b0) begin
            cs_rises <= cs_rises + 1;
            cs_rise_at <= cyc;
        end
        if (empty === 1'b0) empty_lows <= empty_lows + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compares one observed value with its expectation.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Offers one word and holds it until the edge that takes it.
    task automatic push(input logic [7:0] d);
        int n;
        n = 0;
        tx_data <= d;
        tx_valid <= 1'b1;
        @(posedge mclk);
        while (tx_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        if (tx_ready !== 1'b1) miscompares++;
        tx_valid <= 1'b0;
        @(posedge mclk);
    endtask
    // Waits, under a bound, until every queued transfer has ended.
    task automatic wait_done;
        int n;
        n = 0;
        repeat (6) @(posedge mclk);
        while (done !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        if (done !== 1'b1) miscompares++;
        @(posedge mclk);
    endtask
    // One-cycle read strobes of the receive holding and status registers.
    task automatic read_rx;
        rx_read <= 1'b1;
        @(posedge mclk);
        rx_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic read_status;
        status_read <= 1'b1;
        @(posedge mclk);
        status_read <= 1'b0;
        @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end
    // Main test sequence.
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("cs_n idle", 8'h0F, {4'h0, cs_n});
        chk("done at reset", 8'h00, {7'h0, done});
        spi_enable <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("empty on enable", 8'h01, {7'h0, empty});
        chk("done on enable", 8'h01, {7'h0, done});
        $display("test enable finished");
        // Every polarity and phase setting carries one full-duplex word.
        for (int m = 0; m < 4; m++) begin
            cpol <= m[1];
            cpha <= m[0];
            reply <= 8'h3C ^ 8'(m);
            v = 8'hA1 ^ 8'(m * 17);
            repeat (4) @(posedge mclk);
            mark_e = edges;
            mark_l = empty_lows;
            push(v);
            repeat (3) @(posedge mclk);
            chk("cs low", 8'h00, {7'h0, cs_n[0]});
            wait_done();
            chk("slave got", v, s_got);
            chk("rx word", 8'h3C ^ 8'(m), rx_reg);
            chk("clock edges", 8'h10, 8'(edges - mark_e));
            chk("rx full", 8'h01, {7'h0, rx_full});
            chk("empty dropped", 8'h01, {7'h0, empty_lows != mark_l});
            read_rx();
            chk("rx full read", 8'h00, {7'h0, rx_full});
        end
        $display("test modes finished");
        mark_e = cs_rises;
        reply <= 8'h5A;
        push(8'h11);
        push(8'h22);
        push(8'h33);
        wait_done();
        chk("one select", 8'h01, 8'(cs_rises - mark_e));
        chk("last word", 8'h33, s_got);
        chk("overrun", 8'h01, {7'h0, ovr});
        chk("overwrite", 8'h5A, rx_reg);
        read_status();
        chk("overrun read", 8'h00, {7'h0, ovr});
        read_rx();
        $display("test back_to_back finished");
        sel <= 2'h2;
        push(8'h77);
        repeat (3) @(posedge mclk);
        chk("select two", 8'h0B, {4'h0, cs_n});
        wait_done();
        sel <= 2'h0;
        read_rx();
        wrbs <= 1'b1;
        push(8'h44);
        wait_done();
        push(8'h55);
        repeat (100) @(posedge mclk);
        chk("held off", 8'h01, {7'h0, cs_n[0]});
        chk("held word", 8'h44, s_got);
        read_rx();
        wait_done();
        chk("released word", 8'h55, s_got);
        read_rx();
        wrbs <= 1'b0;
        $display("test select_and_wait finished");
        itd <= 8'h04;
        push(8'hFF);
        wait_done();
        gap = cs_rise_at - last_edge;
        chk("trail gap", 8'h01, {7'h0, gap >= 16 && gap <= 20});
        chk("done after trail", 8'h01, {7'h0, done});
        chk("dummy rx", 8'h5A, rx_reg);
        itd <= 8'h00;
        read_rx();
        $display("test delay finished");
        spi_enable <= 1'b0;
        repeat (3) @(posedge mclk);
        acc = 0;
        tx_data <= 8'h90;
        tx_valid <= 1'b1;
        repeat (15) begin
            @(posedge mclk);
            if (tx_ready === 1'b1) acc++;
            tx_data <= 8'h90 + 8'(acc);
        end
        tx_valid <= 1'b0;
        chk("fifo refuses", 8'h00, {7'h0, tx_ready});
        chk("fifo depth", 8'h08, 8'(acc));
        spi_enable <= 1'b1;
        wait_done();
        chk("drained word", 8'h90 + 8'(acc - 1), s_got);
        chk("fifo open", 8'h01, {7'h0, tx_ready});
        $display("test fifo finished");
        tally_and_finish();
    end
endmodule // smte_top_tb

// *** design/smte_fifo.sv ***
// Word FIFO that queues transmit words ahead of the holding register.
`timescale 1ns/1ps
module smte_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic mclk,
    input wire logic rst,
    smte_fifo_if.snk push,
    smte_fifo_if.src pop
);
    import smte_pkg::*;
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic room;
    } smte_fifo_s;
    smte_fifo_s st_ff;
    smte_fifo_s nxt_st;
    logic do_push;
    logic do_pop;

    ////////////////////////////////////////////////////////////////////////
    // Ready has a flop of its own; valid comes from the stored count.
    assign push.ready = st_ff.room;
    assign pop.valid = (st_ff.cnt != '0);
    assign pop.data = st_ff.mem[st_ff.rp];
    assign do_push = push.valid && push.ready;
    assign do_pop = pop.valid && pop.ready;

    // Next state: write at the tail, read at the head, track the fill.
    always_comb begin
        nxt_st = st_ff;
        if (do_push) begin
            nxt_st.mem[st_ff.wp] = push.data;
            nxt_st.wp = (st_ff.wp == AW'(D-1)) ? '0 : st_ff.wp + 1'b1;
        end
        if (do_pop) begin
            nxt_st.rp = (st_ff.rp == AW'(D-1)) ? '0 : st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        nxt_st.room = (nxt_st.cnt != (AW+1)'(D));
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.room <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The fill never passes the depth.
    chk_fifo_bound: assert property (@(posedge mclk) disable iff (rst)
        st_ff.cnt <= (AW+1)'(D)) else $error("FIFO count above depth.");
endmodule // smte_fifo

// *** design/smte_fifo_if.sv ***
// Valid and ready word channel between the engine's own modules.
`timescale 1ns/1ps
interface smte_fifo_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** design/smte_params.svh ***
// Constants for the serial master transfer engine.
`ifndef SMTE_PARAMS_SVH
`define SMTE_PARAMS_SVH
`define SMTE_WORD_W 8
`define SMTE_FIFO_DEPTH 8
`define SMTE_SEL_W 2
`define SMTE_BAUD_W 8
`define SMTE_DLY_W 8
`define SMTE_RST_FLAG 1'b0
`define SMTE_RST_CS_N 1'b1
`endif

// *** design/smte_pkg.sv ***
// Types shared by the serial master transfer engine.
package smte_pkg;
    // Transfer states, Gray coded along idle, shift, trail.
    typedef enum logic [1:0] {
        SMTE_IDLE  = 2'b00,
        SMTE_SHIFT = 2'b01,
        SMTE_TRAIL = 2'b11
    } smte_state_e;
endpackage

// *** design/smte_top.sv ***
// Master-mode serial transfer engine with holding registers and flags.
// Summary of operation
// RULE1: Divider makes serial clock; drive clock and select.
// RULE2: One transmit holding, one receive holding, one shifter.
// RULE3: Enabled idle engine starts a written word at once.
// RULE4: Sample input into the shifter while shifting out.
// RULE5: Receive-only software writes dummy ones to clock.
// RULE6: Wait-for-read holds transfers until receive word read.
// RULE7: Software picks the slave before writing a word.
// RULE8: Queued word loads at completion; next transfer starts.
// RULE9: Empty flag clears on write, sets on load.
// RULE10: Done flag sets after trailing delay of last word.
// RULE11: Clock may stop only after done flag is seen.
// RULE12: Enabling sets the empty and done flags.
// RULE13: Full flag sets on receive load, clears on read.
// RULE14: Unread word overwritten sets overrun; status read clears.
// RULE15: Transmit-only use may ignore receive flags.
// RULE16: Drive and sample on edges the mode defines.
// RULE17: Select held through word and trailing delay.
`timescale 1ns/1ps
`include "smte_params.svh"
module smte_top #(
    parameter int W = `SMTE_WORD_W,
    parameter int DEPTH = `SMTE_FIFO_DEPTH,
    parameter int SW = `SMTE_SEL_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic spi_enable,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [`SMTE_BAUD_W-1:0] baud_div,
    input wire logic [`SMTE_DLY_W-1:0] inter_transfer_delay,
    input wire logic wait_read_before_send,
    input wire logic [SW-1:0] slave_select_field,
    input wire logic [W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic rx_read,
    input wire logic status_read,
    output logic [W-1:0] rx_holding_reg,
    output logic tx_holding_empty,
    output logic tx_all_done,
    output logic rx_holding_full,
    output logic rx_overrun_flag,
    output logic serial_clock_out,
    output logic mosi,
    input wire logic miso,
    output logic [(1<<SW)-1:0] cs_n
);
    import smte_pkg::*;
    localparam int NCS = 1 << SW;
    localparam int EW = $clog2(2*W) + 1;

    typedef struct packed {
        smte_state_e state;
        logic en;
        logic [W-1:0] tx_hold;
        logic tx_full;
        logic empty;
        logic [W-1:0] shreg;
        logic samp;
        logic [EW-1:0] edge_cnt;
        logic phase;
        logic [`SMTE_BAUD_W-1:0] baud_cnt;
        logic [`SMTE_DLY_W-1:0] dly_cnt;
        logic [W-1:0] rx_hold;
        logic rx_full;
        logic ovr;
        logic done;
        logic sck;
        logic mosi;
        logic [NCS-1:0] cs_n;
        logic [1:0] miso_sync;
    } smte_core_s;

    smte_core_s st_ff;
    smte_core_s nxt_st;
    logic tick;
    logic last_edge;
    logic may_start;
    logic [W-1:0] rx_word;

    smte_fifo_if #(.W(W)) q_in ();
    smte_fifo_if #(.W(W)) q_out ();

    // Active-low one-hot select for the chosen slave.
    function automatic logic [NCS-1:0] sel_decode(input logic [SW-1:0] sel);
        logic [NCS-1:0] v;
        v = '1;
        v[sel] = 1'b0;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Transmit words queue in the FIFO ahead of the holding register.
    assign q_in.valid = tx_valid;
    assign q_in.data = tx_data;
    assign tx_ready = q_in.ready;
    assign q_out.ready = st_ff.en && !st_ff.tx_full;

    smte_fifo #(.W(W), .D(DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .push(q_in.snk),
        .pop(q_out.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Baud divider gives one half-period enable pulse per terminal count.
    assign tick = (st_ff.state == SMTE_SHIFT) && (st_ff.baud_cnt == baud_div); // RULE1
    assign last_edge = tick && (st_ff.edge_cnt == EW'(2*W-1));
    // Wait-for-read blocks a start while an unread word sits in receive.
    assign may_start = st_ff.tx_full && !(wait_read_before_send && st_ff.rx_full); // RULE6
    // The last bit joins from the sample latch in early sampling, and
    // straight from the synchroniser when it is sampled on the final edge.
    assign rx_word = cpha ? {st_ff.shreg[W-2:0], st_ff.miso_sync[1]} :
        {st_ff.shreg[W-2:0], st_ff.samp}; // RULE4

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole engine.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.miso_sync = {st_ff.miso_sync[0], miso};
        nxt_st.en = spi_enable;
        // Holding register refills from the FIFO and clears the empty flag.
        if (q_out.valid && q_out.ready) begin
            nxt_st.tx_hold = q_out.data; // RULE2
            nxt_st.tx_full = 1'b1; // RULE9
        end
        // A read of the receive holding register drops the full flag.
        if (rx_read) begin
            nxt_st.rx_full = 1'b0; // RULE13
        end
        // A status read clears overrun; a new overrun below wins.
        if (status_read) begin
            nxt_st.ovr = 1'b0; // RULE14
        end
        unique case (st_ff.state)
            SMTE_IDLE: begin
                nxt_st.sck = cpol;
                nxt_st.baud_cnt = '0;
                nxt_st.cs_n = '1;
                // Start as soon as a word is held; the empty flag sets.
                if (st_ff.en && may_start) begin
                    nxt_st.shreg = st_ff.tx_hold; // RULE3
                    nxt_st.tx_full = 1'b0; // RULE9
                    nxt_st.done = 1'b0;
                    nxt_st.edge_cnt = '0;
                    nxt_st.phase = 1'b0;
                    nxt_st.cs_n = sel_decode(slave_select_field); // RULE1 RULE17
                    nxt_st.state = SMTE_SHIFT;
                end
            end
            SMTE_SHIFT: begin
                nxt_st.baud_cnt = tick ? '0 : st_ff.baud_cnt + 1'b1;
                if (tick) begin
                    nxt_st.phase = !st_ff.phase;
                    nxt_st.sck = !st_ff.sck; // RULE1
                    nxt_st.edge_cnt = st_ff.edge_cnt + 1'b1;
                    // Leading edge samples in mode 0; trailing in mode 1.
                    if (st_ff.phase == cpha) begin
                        nxt_st.samp = st_ff.miso_sync[1]; // RULE4 RULE16
                    end else if (!(cpha && st_ff.edge_cnt == '0)) begin
                        nxt_st.shreg = {st_ff.shreg[W-2:0], st_ff.samp}; // RULE4 RULE16
                    end
                end
                // Completion moves the word to the receive holding register.
                if (last_edge) begin
                    nxt_st.rx_hold = rx_word; // RULE8
                    nxt_st.rx_full = 1'b1; // RULE13
                    if (st_ff.rx_full && !rx_read) begin
                        nxt_st.ovr = 1'b1; // RULE14
                    end
                    nxt_st.dly_cnt = '0;
                    nxt_st.sck = cpol;
                    nxt_st.state = SMTE_TRAIL;
                end
            end
            SMTE_TRAIL: begin
                nxt_st.baud_cnt = (st_ff.baud_cnt == baud_div) ? '0 : st_ff.baud_cnt + 1'b1;
                if (st_ff.dly_cnt == inter_transfer_delay) begin
                    // A queued word starts at once with select kept low.
                    if (st_ff.en && may_start) begin
                        nxt_st.shreg = st_ff.tx_hold; // RULE8
                        nxt_st.tx_full = 1'b0; // RULE9
                        nxt_st.edge_cnt = '0;
                        nxt_st.phase = 1'b0;
                        nxt_st.baud_cnt = '0;
                        nxt_st.state = SMTE_SHIFT;
                    end else begin
                        nxt_st.done = 1'b1; // RULE10
                        nxt_st.cs_n = '1; // RULE17
                        nxt_st.state = SMTE_IDLE;
                    end
                end else if (st_ff.baud_cnt == baud_div) begin
                    nxt_st.dly_cnt = st_ff.dly_cnt + 1'b1; // RULE10
                end
            end
            default: begin
                nxt_st.state = SMTE_IDLE;
            end
        endcase
        // Disabling halts any transfer and drops the held word, though the FIFO still takes words; enabling shows empty and done.
        if (!st_ff.en) begin
            nxt_st.state = SMTE_IDLE;
            nxt_st.tx_full = 1'b0;
            nxt_st.cs_n = '1;
            nxt_st.sck = cpol;
            nxt_st.done = spi_enable; // RULE12
        end
        // The request flag is registered so that its pin comes from a flop.
        nxt_st.empty = nxt_st.en && !nxt_st.tx_full; // RULE9 RULE12
        nxt_st.mosi = nxt_st.shreg[W-1];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, cleared by the synchronous reset except the selects, which reset high.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.state <= SMTE_IDLE;
            st_ff.done <= `SMTE_RST_FLAG;
            st_ff.cs_n <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops.
    assign rx_holding_reg = st_ff.rx_hold;
    assign tx_holding_empty = st_ff.empty; // RULE9 RULE12
    assign tx_all_done = st_ff.done;
    assign rx_holding_full = st_ff.rx_full;
    assign rx_overrun_flag = st_ff.ovr;
    assign serial_clock_out = st_ff.sck;
    assign mosi = st_ff.mosi;
    assign cs_n = st_ff.cs_n;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the engine.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_start_at_once: assert property ( // RULE3
        st_ff.en && spi_enable && st_ff.state == SMTE_IDLE && may_start
        |=> st_ff.state == SMTE_SHIFT && !st_ff.tx_full)
        else $error("Held word did not start.");
    chk_wait_read: assert property ( // RULE6
        wait_read_before_send && st_ff.rx_full && st_ff.state == SMTE_IDLE
        |=> st_ff.state == SMTE_IDLE)
        else $error("Transfer started with unread receive word.");
    chk_rx_full_set: assert property ( // RULE13
        last_edge && st_ff.en && spi_enable |=> st_ff.rx_full && st_ff.rx_hold == $past(rx_word))
        else $error("Receive word not captured.");
    chk_rx_full_clear: assert property ( // RULE13
        rx_read && !last_edge |=> !st_ff.rx_full)
        else $error("Read did not clear full flag.");
    chk_overrun_set: assert property ( // RULE14
        last_edge && st_ff.rx_full && !rx_read && st_ff.en |=> st_ff.ovr)
        else $error("Overrun not flagged.");
    chk_overrun_clear: assert property ( // RULE14
        status_read && !last_edge |=> !st_ff.ovr)
        else $error("Status read did not clear overrun.");
    chk_enable_flags: assert property ( // RULE12
        !st_ff.en && spi_enable ##1 spi_enable |-> tx_holding_empty && tx_all_done)
        else $error("Enable did not set flags.");
    chk_cs_hold: assert property ( // RULE17
        st_ff.state != SMTE_IDLE |-> cs_n != '1)
        else $error("Select dropped during transfer.");
    chk_sck_idle: assert property ( // RULE16
        st_ff.state == SMTE_IDLE && $past(st_ff.state) == SMTE_IDLE && $stable(cpol)
        |-> serial_clock_out == cpol)
        else $error("Serial clock not at idle level.");
    chk_done_quiet: assert property ( // RULE10
        st_ff.state == SMTE_SHIFT |-> !tx_all_done)
        else $error("Done flag set while shifting.");
    // A load into the holding register drops the request flag.
    chk_empty_clear: assert property ( // RULE9
        q_out.valid && q_out.ready |=> !tx_holding_empty)
        else $error("Empty flag stayed set after load.");
    // A start empties the holding register and raises the request flag.
    chk_empty_set: assert property ( // RULE9
        st_ff.en && spi_enable && st_ff.state == SMTE_IDLE && may_start |=> tx_holding_empty)
        else $error("Empty flag not set on start.");
    // The end of the trailing delay with nothing queued ends the run.
    chk_done_set: assert property ( // RULE10
        st_ff.en && spi_enable && st_ff.state == SMTE_TRAIL && !may_start
        && st_ff.dly_cnt == inter_transfer_delay |=> tx_all_done && cs_n == '1)
        else $error("Done flag not set after delay.");
    // The done flag waits for the whole trailing delay.
    chk_trail_quiet: assert property ( // RULE10
        st_ff.state == SMTE_TRAIL |-> !tx_all_done)
        else $error("Done flag set inside trailing delay.");
    // The first data line bit is the top bit of the held word.
    chk_mosi_first: assert property ( // RULE4
        st_ff.en && st_ff.state == SMTE_IDLE && may_start |=> mosi == $past(st_ff.tx_hold[W-1]))
        else $error("First output bit wrong.");
    // Exactly one slave is selected while a transfer runs.
    chk_cs_onehot: assert property ( // RULE1
        st_ff.state != SMTE_IDLE |-> $countones(~cs_n) == 1)
        else $error("Select not one-hot during transfer.");
    // The serial clock returns to its idle level after the last edge.
    chk_sck_rest: assert property ( // RULE16
        last_edge && st_ff.en |=> serial_clock_out == $past(cpol))
        else $error("Serial clock not at rest after word.");
endmodule // smte_top
